// [verilog/itbc_pkg.sv]
// Shared constants of the interval timer host port and its bus controller.
package itbc_pkg;
  // Port-select code of the control port, and select-counter code of the read-back command.
  localparam logic [1:0]  ITBC_PS_CTRL      = 2'h3;
  localparam logic [1:0]  ITBC_SC_READBACK  = 2'h3;
  // Control word field positions.
  localparam int          ITBC_CW_SC_POS    = 6;
  localparam int          ITBC_CW_FMT_POS   = 4;
  localparam int          ITBC_CW_MODE_POS  = 1;
  localparam int          ITBC_CW_BCD_POS   = 0;
  // Read-back command field positions (count and status selects are active low).
  localparam int          ITBC_RB_CNT_N_POS = 5;
  localparam int          ITBC_RB_STA_N_POS = 4;
  localparam int          ITBC_RB_MASK_POS  = 1;
  // Byte format codes.
  localparam logic [1:0]  ITBC_FMT_LATCH    = 2'h0;
  localparam logic [1:0]  ITBC_FMT_LSB      = 2'h1;
  localparam logic [1:0]  ITBC_FMT_MSB      = 2'h2;
  localparam logic [1:0]  ITBC_FMT_BOTH     = 2'h3;
  // Reset values.
  localparam logic [7:0]  ITBC_RST_BYTE     = 8'h00;
  localparam logic [15:0] ITBC_RST_WORD     = 16'h0000;
  localparam logic [31:0] ITBC_RST_BUS      = 32'h0000_0000;
  // Host strobe timing.
  localparam int          ITBC_CLK_NS       = 10;
  localparam int          ITBC_STROBE_NS    = 30;
  localparam logic [1:0]  ITBC_STROBE_CYC   = 2'((ITBC_STROBE_NS + ITBC_CLK_NS - 1) / ITBC_CLK_NS);
  // Controller registers on the AHB-Lite side.
  localparam logic [7:0]  ITBC_CMD_OFS      = 8'h00;
  localparam logic [7:0]  ITBC_STAT_OFS     = 8'h04;
  localparam logic [7:0]  ITBC_RDATA_OFS    = 8'h08;
  localparam int          ITBC_CMD_PS_POS   = 8;
  localparam int          ITBC_CMD_RD_POS   = 10;
endpackage : itbc_pkg

// [verilog/itbc_bus_if.sv]
// Host port between the timer device and its bus controller.
`timescale 1ns/1ps
interface itbc_bus_if;
  logic       cs_n;         // Chip select, active low.
  logic       rd_n;         // Read strobe, active low.
  logic       wr_n;         // Write strobe, active low.
  logic [1:0] port_select;  // Target port.
  logic [7:0] host_dout;    // Host drive value.
  logic       host_oe;      // Host drives data.
  logic [7:0] dev_dout;     // Device drive value.
  logic       dev_oe;       // Device drives data.
  logic [7:0] data;         // Resolved data wire.

  // An undriven wire reads as all ones, like a pulled-up bus.
  assign data = dev_oe ? dev_dout : (host_oe ? host_dout : 8'hFF);

  modport dev  (input cs_n, rd_n, wr_n, port_select, data, output dev_dout, dev_oe);
  modport host (output cs_n, rd_n, wr_n, port_select, host_dout, host_oe, input data);
endinterface : itbc_bus_if

// [verilog/itbc_device.sv]
// Three-channel interval timer: host port decode, control word, preload, snapshot and counting element.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module itbc_device
  import itbc_pkg::*;
(
  input  wire logic       clk,        // System clock, 100 MHz.
  input  wire logic       rst_n,      // Synchronous reset, active low.
  itbc_bus_if.dev         bus,        // Host port.
  input  wire logic [2:0] count_clk,  // Per-channel count clock pins.
  input  wire logic [2:0] gate,       // Per-channel gate pins.
  output logic      [2:0] timer_out   // Per-channel output lines.
);

  typedef struct packed {
    logic [5:0]  ctrl;      // Raw format, mode and decimal bits.
    logic [2:0]  mode;      // Normalised mode number.
    logic        armed;     // Channel has been programmed.
    logic [15:0] preload;   // Preload pair.
    logic [15:0] count;     // Counting element.
    logic [15:0] snap;      // Snapshot latch pair.
    logic        frozen;    // Snapshot held for the host.
    logic [7:0]  status;    // Status snapshot.
    logic        stat_vld;  // Status snapshot pending read.
    logic        wr_hi;     // Next count byte is the high one.
    logic        rd_hi;     // Next read byte is the high one.
    logic        pending;   // Preload waiting for transfer.
    logic        out;       // Output line level.
  } itbc_chan_type;

  typedef struct packed {
    itbc_chan_type [2:0] ch;
    logic [2:0]  ck_s1;     // Count clock synchroniser stages.
    logic [2:0]  ck_s2;
    logic [2:0]  ck_s3;
    logic [2:0]  ck_f;      // Filtered count clock.
    logic [2:0]  gt_s1;     // Gate synchroniser stages.
    logic [2:0]  gt_s2;
    logic [2:0]  gt_s3;
    logic [2:0]  gt_f;      // Filtered gate.
    logic        wr_n_prev; // Write strobe one cycle ago.
    logic        rd_act;    // Qualified counter read in progress.
    logic [1:0]  rd_sel;    // Counter being read.
    logic [7:0]  rd_byte;   // Byte presented on the data port.
  } itbc_dev_type;

  itbc_dev_type st_q;
  itbc_dev_type st_d;

  // Four-decade decimal decrement; 0000 wraps to 9999.
  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (borrow) begin
        if (v[k*4 +: 4] == 4'h0) begin
          r[k*4 +: 4] = 4'h9;
        end else begin
          r[k*4 +: 4] = v[k*4 +: 4] - 4'h1;
          borrow      = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_dec

  // Byte of a channel that the host sees next: status first, then snapshot bytes.
  function automatic logic [7:0] read_byte(input itbc_chan_type c);
    logic [7:0] r;
    r = c.snap[7:0];
    if (c.stat_vld) begin
      r = c.status;
    end else if (c.ctrl[5:4] == ITBC_FMT_MSB || (c.ctrl[5:4] == ITBC_FMT_BOTH && c.rd_hi)) begin
      r = c.snap[15:8];
    end
    return r;
  endfunction : read_byte

  logic       cs_ok;
  logic       wr_fall;
  logic       rd_now;
  logic [7:0] cw;

  // Strobes only count while chip select is low; a read of the control port never drives.
  assign cs_ok       = !bus.cs_n;
  assign wr_fall     = cs_ok && st_q.wr_n_prev && !bus.wr_n;
  assign rd_now      = cs_ok && !bus.rd_n && bus.port_select != ITBC_PS_CTRL;
  assign cw          = bus.data;
  assign bus.dev_oe  = rd_now;
  assign bus.dev_dout = st_q.rd_byte;
  assign timer_out   = {st_q.ch[2].out, st_q.ch[1].out, st_q.ch[0].out};

  // Next-state logic: synchronisers, counting, host writes, host reads.
  always_comb begin
    st_d = st_q;
    st_d.ck_s1 = count_clk;
    st_d.ck_s2 = st_q.ck_s1;
    st_d.ck_s3 = st_q.ck_s2;
    st_d.gt_s1 = gate;
    st_d.gt_s2 = st_q.gt_s1;
    st_d.gt_s3 = st_q.gt_s2;
    st_d.wr_n_prev = bus.wr_n;

    // Counting runs per channel with no shared state between channels.
    for (int i = 0; i < 3; i++) begin
      if (st_q.ck_s2[i] == st_q.ck_s3[i]) begin
        st_d.ck_f[i] = st_q.ck_s3[i];
      end
      if (st_q.gt_s2[i] == st_q.gt_s3[i]) begin
        st_d.gt_f[i] = st_q.gt_s3[i];
      end
      if (st_d.ck_f[i] && !st_q.ck_f[i] && st_q.ch[i].armed) begin
        if (st_q.ch[i].pending) begin
          st_d.ch[i].count   = st_q.ch[i].preload;
          st_d.ch[i].pending = 1'b0;
        end else if (st_q.gt_f[i]) begin
          st_d.ch[i].count = st_q.ch[i].ctrl[0] ? bcd_dec(st_q.ch[i].count)
                                                : st_q.ch[i].count - 16'h0001;
          if (st_q.ch[i].count == 16'h0001) begin
            st_d.ch[i].out = 1'b1;
          end
        end
      end
      // Snapshot follows the counting element unless frozen.
      if (!st_q.ch[i].frozen) begin
        st_d.ch[i].snap = st_q.ch[i].count;
      end
    end

    // Host write: control word port or a counter's own port.
    if (wr_fall) begin
      if (bus.port_select == ITBC_PS_CTRL) begin
        if (cw[ITBC_CW_SC_POS +: 2] == ITBC_SC_READBACK) begin
          for (int i = 0; i < 3; i++) begin
            if (cw[ITBC_RB_MASK_POS + i]) begin
              if (!cw[ITBC_RB_CNT_N_POS] && !st_q.ch[i].frozen) begin
                st_d.ch[i].frozen = 1'b1;
                st_d.ch[i].snap   = st_q.ch[i].count;
              end
              if (!cw[ITBC_RB_STA_N_POS] && !st_q.ch[i].stat_vld) begin
                st_d.ch[i].stat_vld = 1'b1;
                st_d.ch[i].status   = {st_q.ch[i].out, st_q.ch[i].pending, st_q.ch[i].ctrl};
              end
            end
          end
        end else begin
          for (int i = 0; i < 3; i++) begin
            if (cw[ITBC_CW_SC_POS +: 2] == 2'(i)) begin
              if (cw[ITBC_CW_FMT_POS +: 2] == ITBC_FMT_LATCH) begin
                // A second latch before the read is ignored.
                if (!st_q.ch[i].frozen) begin
                  st_d.ch[i].frozen = 1'b1;
                  st_d.ch[i].snap   = st_q.ch[i].count;
                end
              end else begin
                st_d.ch[i].ctrl     = cw[5:0];
                st_d.ch[i].mode     = cw[ITBC_CW_MODE_POS + 1] ? {1'b0, cw[2:1]}
                                                               : cw[3:1];
                st_d.ch[i].armed    = 1'b1;
                st_d.ch[i].preload  = ITBC_RST_WORD;
                st_d.ch[i].wr_hi    = 1'b0;
                st_d.ch[i].rd_hi    = 1'b0;
                st_d.ch[i].frozen   = 1'b0;
                st_d.ch[i].stat_vld = 1'b0;
                st_d.ch[i].pending  = 1'b1;
                st_d.ch[i].out      = 1'b0;
              end
            end
          end
        end
      end else begin
        // Count bytes land in the preload pair only, in the channel's own format.
        for (int i = 0; i < 3; i++) begin
          if (bus.port_select == 2'(i) && st_q.ch[i].armed) begin
            case (st_q.ch[i].ctrl[5:4])
              ITBC_FMT_LSB: begin
                st_d.ch[i].preload[7:0] = cw;
                st_d.ch[i].pending      = 1'b1;
              end
              ITBC_FMT_MSB: begin
                st_d.ch[i].preload[15:8] = cw;
                st_d.ch[i].pending       = 1'b1;
              end
              ITBC_FMT_BOTH: begin
                if (!st_q.ch[i].wr_hi) begin
                  st_d.ch[i].preload[7:0] = cw;
                  st_d.ch[i].wr_hi        = 1'b1;
                end else begin
                  st_d.ch[i].preload[15:8] = cw;
                  st_d.ch[i].wr_hi         = 1'b0;
                  st_d.ch[i].pending       = 1'b1;
                end
              end
              default: begin
                st_d.ch[i].pending = st_q.ch[i].pending;
              end
            endcase
          end
        end
      end
    end

    // Host read: present the byte; at the end of the strobe step to the next one.
    st_d.rd_act  = rd_now;
    st_d.rd_sel  = bus.port_select;
    st_d.rd_byte = ITBC_RST_BYTE;
    for (int i = 0; i < 3; i++) begin
      if (bus.port_select == 2'(i)) begin
        st_d.rd_byte = read_byte(st_q.ch[i]);
      end
      if (st_q.rd_act && !rd_now && st_q.rd_sel == 2'(i)) begin
        if (st_q.ch[i].stat_vld) begin
          st_d.ch[i].stat_vld = 1'b0;
        end else if (st_q.ch[i].ctrl[5:4] == ITBC_FMT_BOTH && !st_q.ch[i].rd_hi) begin
          st_d.ch[i].rd_hi = 1'b1;
        end else begin
          st_d.ch[i].rd_hi  = 1'b0;
          // A latch taken in this same cycle wins over the unfreeze.
          st_d.ch[i].frozen = st_d.ch[i].frozen && !st_q.ch[i].frozen;
        end
      end
    end
  end

  // State register; reset gives a defined but meaningless start for unprogrammed channels.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.wr_n_prev <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : itbc_device

// [verilog/itbc_host.sv]
// Bus controller that drives the timer host port on orders taken over AHB-Lite.
`timescale 1ns/1ps
module itbc_host
  import itbc_pkg::*;
(
  input  wire logic        clk,        // System clock, 100 MHz.
  input  wire logic        rst_n,      // Synchronous reset, active low.
  itbc_bus_if.host         bus,        // Host port.
  input  wire logic        hsel,       // AHB slave select.
  input  wire logic [31:0] haddr,      // AHB address.
  input  wire logic [1:0]  htrans,     // AHB transfer type.
  input  wire logic        hwrite,     // AHB write.
  input  wire logic [2:0]  hsize,      // AHB size, word only.
  input  wire logic [31:0] hwdata,     // AHB write data.
  input  wire logic        hready,     // AHB bus ready.
  output logic             hreadyout,  // AHB slave ready.
  output logic      [31:0] hrdata,     // AHB read data.
  output logic             hresp       // AHB response, always OKAY.
);

  typedef enum logic [3:0] {
    ITBC_H_IDLE   = 4'b0001,
    ITBC_H_SETUP  = 4'b0010,
    ITBC_H_STROBE = 4'b0100,
    ITBC_H_HOLD   = 4'b1000
  } itbc_hstate_type;

  typedef struct packed {
    itbc_hstate_type fsm;
    logic [1:0]      cnt;      // Strobe cycles left.
    logic            is_rd;    // Order is a read.
    logic [1:0]      ps;       // Port select.
    logic [7:0]      wdata;    // Byte to write.
    logic [7:0]      rdata;    // Last byte read.
    logic            cs_n;
    logic            rd_n;
    logic            wr_n;
    logic            oe;
    logic            ap_wr;    // Write data phase pending.
    logic [7:0]      ap_addr;  // Address of pending write.
    logic [31:0]     hrdata;
  } itbc_host_type;

  itbc_host_type st_q;
  itbc_host_type st_d;

  logic ap_take;

  // Zero-wait slave: every address phase is taken at once.
  assign ap_take       = hsel && htrans[1] && hready;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = st_q.hrdata;
  assign bus.cs_n      = st_q.cs_n;
  assign bus.rd_n      = st_q.rd_n;
  assign bus.wr_n      = st_q.wr_n;
  assign bus.port_select = st_q.ps;
  assign bus.host_dout = st_q.wdata;
  assign bus.host_oe   = st_q.oe;

  // Register access and the port cycle sequencer.
  always_comb begin
    st_d       = st_q;
    st_d.ap_wr = ap_take && hwrite;
    if (ap_take) begin
      st_d.ap_addr = haddr[7:0];
      st_d.hrdata  = ITBC_RST_BUS;
      if (!hwrite && haddr[7:0] == ITBC_STAT_OFS) begin
        st_d.hrdata = {31'h0, st_q.fsm != ITBC_H_IDLE};
      end else if (!hwrite && haddr[7:0] == ITBC_RDATA_OFS) begin
        st_d.hrdata = {24'h0, st_q.rdata};
      end
    end
    case (st_q.fsm)
      ITBC_H_IDLE: begin
        // An order written while busy is dropped; software polls the busy bit.
        if (st_q.ap_wr && st_q.ap_addr == ITBC_CMD_OFS) begin
          st_d.is_rd = hwdata[ITBC_CMD_RD_POS];
          st_d.ps    = hwdata[ITBC_CMD_PS_POS +: 2];
          st_d.wdata = hwdata[7:0];
          st_d.cs_n  = 1'b0;
          st_d.oe    = !hwdata[ITBC_CMD_RD_POS];
          st_d.fsm   = ITBC_H_SETUP;
        end
      end
      ITBC_H_SETUP: begin
        st_d.rd_n = !st_q.is_rd;
        st_d.wr_n = st_q.is_rd;
        st_d.cnt  = ITBC_STROBE_CYC;
        st_d.fsm  = ITBC_H_STROBE;
      end
      ITBC_H_STROBE: begin
        st_d.cnt = st_q.cnt - 2'h1;
        if (st_q.cnt == 2'h1) begin
          if (st_q.is_rd) begin
            st_d.rdata = bus.data;
          end
          st_d.rd_n = 1'b1;
          st_d.wr_n = 1'b1;
          st_d.fsm  = ITBC_H_HOLD;
        end
      end
      ITBC_H_HOLD: begin
        st_d.cs_n = 1'b1;
        st_d.oe   = 1'b0;
        st_d.fsm  = ITBC_H_IDLE;
      end
      default: begin
        st_d.fsm = ITBC_H_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q      <= '0;
      st_q.fsm  <= ITBC_H_IDLE;
      st_q.cs_n <= 1'b1;
      st_q.rd_n <= 1'b1;
      st_q.wr_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : itbc_host

// [tb/itbc_bus_chk.sv]
// Concurrent checks on the host port that joins the timer device and its bus controller.
`timescale 1ns/1ps
module itbc_bus_chk
  import itbc_pkg::*;
(
  input wire logic       clk,          // System clock.
  input wire logic       rst_n,        // Synchronous reset, active low.
  input wire logic       cs_n,         // Chip select, active low.
  input wire logic       rd_n,         // Read strobe, active low.
  input wire logic       wr_n,         // Write strobe, active low.
  input wire logic [1:0] port_select,  // Target port.
  input wire logic [7:0] host_dout,    // Host drive value.
  input wire logic       host_oe,      // Host drives data.
  input wire logic [7:0] dev_dout,     // Device drive value.
  input wire logic       dev_oe,       // Device drives data.
  input wire logic [7:0] data          // Resolved data wire.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Each strobe stays low for three cycles, then rises again.
  sequence s_rd_pulse;
    !rd_n [*3] ##1 rd_n;
  endsequence
  sequence s_wr_pulse;
    !wr_n [*3] ##1 wr_n;
  endsequence
  // A qualified counter read; only this may turn the device driver on.
  sequence s_cnt_read;
    !cs_n && !rd_n && port_select != ITBC_PS_CTRL;
  endsequence

  a_oe_qualified: assert property (dev_oe |-> !cs_n && !rd_n && port_select != ITBC_PS_CTRL)
    else $error("device drives the data port outside a counter read");
  a_read_drives: assert property (s_cnt_read |-> dev_oe)
    else $error("device silent during a counter read");
  a_ctrl_undriven: assert property (!cs_n && !rd_n && port_select == ITBC_PS_CTRL |-> data == 8'hFF)
    else $error("control port read returned driven data");
  a_rd_width: assert property ($fell(rd_n) |-> s_rd_pulse)
    else $error("read strobe width wrong");
  a_wr_width: assert property ($fell(wr_n) |-> s_wr_pulse)
    else $error("write strobe width wrong");
  a_wr_hold: assert property (!wr_n |-> !cs_n && host_oe && !dev_oe && $stable(port_select) && $stable(host_dout))
    else $error("write byte or target moved during the strobe");
  a_rd_no_host: assert property (!rd_n |-> !cs_n && !host_oe)
    else $error("host drives data or lacks select during a read");
  a_wr_release: assert property ($rose(wr_n) |=> cs_n && !host_oe)
    else $error("host kept the port after a write");
  a_strobes_apart: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes low together");
endmodule : itbc_bus_chk

// [tb/tb_interval_timer_bus_and_control.sv]
// Self-checking bench joining the timer device to its bus controller.
`timescale 1ns/1ps
module tb_interval_timer_bus_and_control;
  import itbc_pkg::*;
  logic        clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0]  htrans;
  logic [2:0]  hsize, count_clk, gate, timer_out;
  int          fails, n_compared;
  logic [15:0] exp_cnt [3];
  logic [7:0]  exp_q [$];

  itbc_bus_if i_itbc_bus_if ();
  itbc_device i_itbc_device (.clk(clk), .rst_n(rst_n), .bus(i_itbc_bus_if), .count_clk(count_clk), .gate(gate),
                             .timer_out(timer_out));
  itbc_host i_itbc_host (.clk(clk), .rst_n(rst_n), .bus(i_itbc_bus_if), .hsel(hsel), .haddr(haddr), .htrans(htrans),
                         .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
                         .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  itbc_bus_chk i_itbc_bus_chk (.clk(clk), .rst_n(rst_n), .cs_n(i_itbc_bus_if.cs_n), .rd_n(i_itbc_bus_if.rd_n),
                               .wr_n(i_itbc_bus_if.wr_n), .port_select(i_itbc_bus_if.port_select),
                               .host_dout(i_itbc_bus_if.host_dout), .host_oe(i_itbc_bus_if.host_oe),
                               .dev_dout(i_itbc_bus_if.dev_dout), .dev_oe(i_itbc_bus_if.dev_oe),
                               .data(i_itbc_bus_if.data));

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  // Galois shift register step; each call advances the seed once.
  function automatic logic [15:0] get_rnd();
    seed = seed[0] ? ((seed >> 1) ^ 32'hA300_0000) : (seed >> 1);
    return seed[15:0];
  endfunction : get_rnd

  // One AHB-Lite single word transfer; entered just after a rising edge.
  task automatic ahb(input logic w, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, ofs};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : ahb

  // One host port cycle: order it, wait for the chip select frame to end, then fetch status and byte.
  task automatic op(input logic [1:0] ps, input logic [7:0] b, input logic rd, output logic [7:0] q);
    logic [31:0] d;
    logic        seen;
    seen = 1'b0;
    ahb(1'b1, ITBC_CMD_OFS, {21'h0, rd, ps, b}, d);
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      if (i_itbc_bus_if.cs_n === 1'b0) seen = 1'b1;
      else if (seen) break;
    end
    ahb(1'b0, ITBC_STAT_OFS, 32'h0, d);
    check(d & 32'h1, 32'h0);
    ahb(1'b0, ITBC_RDATA_OFS, 32'h0, d);
    q = d[7:0];
  endtask : op

  // Count pins are slow against the system clock so the synchronisers see every edge.
  task automatic pulse(input logic [1:0] c, input int n);
    repeat (n) begin
      count_clk[c] <= 1'b1;
      repeat (6) @(posedge clk);
      count_clk[c] <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask : pulse

  task automatic read_word(input logic [1:0] c, input logic [15:0] v);
    logic [7:0] q;
    exp_q.push_back(v[7:0]);
    exp_q.push_back(v[15:8]);
    repeat (2) begin
      op(c, 8'h00, 1'b1, q);
      check(q, exp_q.pop_front());
    end
  endtask : read_word

  task automatic read_status(input logic [1:0] c, input logic [7:0] expv);
    logic [7:0] q;
    op(ITBC_PS_CTRL, 8'hE0 | (8'h02 << c), 1'b0, q);
    op(c, 8'h00, 1'b1, q);
    check(q, expv);
  endtask : read_status

  task automatic run_counter(input logic [1:0] c);
    logic [15:0] v1, v2, r;
    logic [7:0]  q;
    v1 = get_rnd();
    v2 = get_rnd();
    r = get_rnd();
    v1 = v1 | 16'h0100;
    v2 = v2 | 16'h0010;
    r = r | 16'h8000;
    op(ITBC_PS_CTRL, {c, ITBC_FMT_BOTH, r[2:0], 1'b0}, 1'b0, q);
    read_status(c, {2'b01, ITBC_FMT_BOTH, r[2:0], 1'b0});
    op(c, v1[7:0], 1'b0, q);
    op(c, v1[15:8], 1'b0, q);
    pulse(c, 1);
    read_word(c, v1);
    read_status(c, {2'b00, ITBC_FMT_BOTH, r[2:0], 1'b0});
    op(c, v2[7:0], 1'b0, q);
    op(c, v2[15:8], 1'b0, q);
    read_word(c, v1);
    pulse(c, 1);
    read_word(c, v2);
    op(ITBC_PS_CTRL, {c, 6'h00}, 1'b0, q);
    gate[c] <= 1'b1;
    // Let the gate pass its synchroniser before the first counted edge.
    repeat (4) @(posedge clk);
    pulse(c, 3);
    gate[c] <= 1'b0;
    read_word(c, v2);
    read_word(c, v2 - 16'h0003);
    op(ITBC_PS_CTRL, {c, ITBC_FMT_MSB, r[2:0], 1'b0}, 1'b0, q);
    op(c, r[15:8], 1'b0, q);
    pulse(c, 1);
    op(c, 8'h00, 1'b1, q);
    check(q, r[15:8]);
    op(ITBC_PS_CTRL, {c, ITBC_FMT_LSB, r[2:0], 1'b0}, 1'b0, q);
    op(c, r[7:0], 1'b0, q);
    pulse(c, 1);
    op(c, 8'h00, 1'b1, q);
    check(q, r[7:0]);
    op(ITBC_PS_CTRL, {c, ITBC_FMT_BOTH, r[2:0], 1'b0}, 1'b0, q);
    exp_cnt[c] = {8'h00, r[7:0]};
    read_word(c, exp_cnt[c]);
  endtask : run_counter

  // Main sequence: reset, per-counter traffic, independence, field decode, then the odd corners.
  initial begin
    logic [7:0]  q;
    logic [31:0] d;
    logic [15:0] r;
    logic [1:0]  f;
    seed = 32'h5C44_EA7B;
    fails = 0;
    n_compared = 0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    count_clk = 3'h0;
    gate = 3'h0;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int c = 0; c < 3; c++) run_counter(2'(c));
    for (int c = 0; c < 3; c++) read_word(2'(c), exp_cnt[c]);
    for (int i = 0; i < 8; i++) begin
      r = get_rnd();
      f = 2'(1 + i % 3);
      op(ITBC_PS_CTRL, {2'(i % 3), f, 3'(i), r[0]}, 1'b0, q);
      read_status(2'(i % 3), {2'b01, f, 3'(i), r[0]});
    end
    // Decimal counting on counter one, then a read-back count latch against a later edge.
    op(ITBC_PS_CTRL, {2'h1, ITBC_FMT_BOTH, 3'h0, 1'b1}, 1'b0, q);
    op(2'h1, 8'h00, 1'b0, q);
    op(2'h1, 8'h01, 1'b0, q);
    gate[1] <= 1'b1;
    pulse(2'h1, 2);
    read_word(2'h1, 16'h0099);
    op(ITBC_PS_CTRL, 8'hD4, 1'b0, q);
    pulse(2'h1, 1);
    read_word(2'h1, 16'h0099);
    read_word(2'h1, 16'h0098);
    // Terminal count on counter zero raises its output line.
    op(ITBC_PS_CTRL, {2'h0, ITBC_FMT_LSB, 3'h0, 1'b0}, 1'b0, q);
    op(2'h0, 8'h02, 1'b0, q);
    pulse(2'h0, 1);
    check({29'h0, timer_out}, 32'h0);
    gate[0] <= 1'b1;
    repeat (4) @(posedge clk);
    pulse(2'h0, 2);
    check({29'h0, timer_out}, 32'h1);
    read_status(2'h0, {1'b1, 1'b0, ITBC_FMT_LSB, 3'h0, 1'b0});
    op(ITBC_PS_CTRL, 8'h00, 1'b1, q);
    check(q, 8'hFF);
    ahb(1'b0, 8'h0C, 32'h0, d);
    check(d, 32'h0);
    test_done();
  end

  // Watchdog far beyond the few thousand cycles the sequence needs.
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule : tb_interval_timer_bus_and_control
